/* File: rtl/shcsr_pkg.sv */
// Package: register map, field positions and types of the switch host registers
package shcsr_pkg;

	// ===========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] NET_CONTROL_OFS  = 8'h00;
	localparam logic [7:0] NET_STATUS_OFS   = 8'h01;
	localparam logic [7:0] TX_CONTROL_OFS   = 8'h02;
	localparam logic [7:0] RX_CONTROL_OFS   = 8'h05;
	localparam logic [7:0] RX_STATUS_OFS    = 8'h06;
	localparam logic [7:0] LOST_COUNT_OFS   = 8'h07;
	localparam logic [7:0] FLOW_CONTROL_OFS = 8'h0A;
	localparam logic [7:0] MGMT_CONTROL_OFS = 8'h0B;
	localparam logic [7:0] MGMT_ADDRESS_OFS = 8'h0C;
	localparam logic [7:0] MGMT_DATA_LO_OFS = 8'h0D;
	localparam logic [7:0] MGMT_DATA_HI_OFS = 8'h0E;

	// ===========================================
	// Field positions
	localparam int CLEAR_MODE_BIT   = 5;
	localparam int LINK_CHANGE_BIT  = 5;
	localparam int SLOT2_SENT_BIT   = 3;
	localparam int SLOT1_SENT_BIT   = 2;
	localparam int SLOT2_NO_FCS_BIT = 3;
	localparam int SLOT1_NO_FCS_BIT = 1;
	localparam int TX_REQUEST_BIT   = 0;
	localparam int HASH_ALL_BIT     = 7;
	localparam int DROP_BAD_FCS_BIT = 4;
	localparam int PASS_MCAST_BIT   = 3;
	localparam int PROMISC_BIT      = 1;
	localparam int RX_ENABLE_BIT    = 0;
	localparam int WRAP_BIT         = 7;
	localparam int FLOW_ENABLE_BIT  = 5;
	localparam int SIZE_FLAG_BIT    = 6;
	localparam int RELOAD_BIT       = 5;
	localparam int WRITE_EN_BIT     = 4;
	localparam int TARGET_SEL_BIT   = 3;
	localparam int READ_CMD_BIT     = 2;
	localparam int WRITE_CMD_BIT    = 1;
	localparam int BUSY_BIT         = 0;

	// ===========================================
	// Writable masks and reset values
	localparam logic [7:0] NET_CONTROL_MASK  = 8'h20;
	localparam logic [7:0] TX_CONTROL_MASK   = 8'h0B;
	localparam logic [7:0] RX_CONTROL_MASK   = 8'hFF;
	localparam logic [7:0] FLOW_CONTROL_MASK = 8'h20;
	localparam logic [7:0] MGMT_CONTROL_MASK = 8'h3E;
	localparam logic [7:0] MGMT_ADDRESS_RST  = 8'h40;
	localparam logic [7:0] BYTE_RST          = 8'h00;
	localparam logic [6:0] COUNT_MAX         = 7'h7F;

	// ===========================================
	// Carriers
	typedef enum logic [1:0] {
		FRAME_RESERVED,
		FRAME_IGMP,
		FRAME_MLD,
		FRAME_BPDU
	} shcsr_frame_kind_t;

	typedef struct packed {
		logic              multicast_flag;
		shcsr_frame_kind_t frame_kind;
		logic [1:0]        source_port;
		logic              fcs_error;
		logic              fifo_overrun_flag;
	} shcsr_rx_status_t;

	typedef struct packed {
		logic receive_enable;
		logic promiscuous_enable;
		logic pass_all_multicast;
		logic drop_bad_fcs;
		logic hash_every_address;
		logic flow_enable;
	} shcsr_rx_ctl_t;

	typedef struct packed {
		logic        go;
		logic        mgmt_target_select;
		logic        is_write;
		logic [1:0]  phy_address_low;
		logic [5:0]  mgmt_word_address;
		logic [15:0] data;
	} shcsr_mgmt_req_t;

endpackage : shcsr_pkg

/* File: rtl/shcsr_regs.sv */
// Module: host control and status register bank on Avalon-MM
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/100ps
// Notes on behaviour
// R1 - Link change on port 0 or 1 sets status bit 5; write 1 clears.
// R2 - Slot 2 done sets status bit 3; slot 1 done sets bit 2.
// R3 - Clear-mode 1: done flags clear by write 1; 0: read or write 1.
// R4 - Transmit request bit starts sending; hardware clears it when sending completes.
// R5 - Control bits 3 and 1 suppress FCS for slots 2 and 1.
// R6 - Receive control holds enable, promiscuous, pass-multicast; all reset to 0.
// R7 - Receive control bit 4 drops frames failing the FCS check.
// R8 - Receive control bit 7 filters every address through the hash table.
// R9 - Read-only receive status: multicast, kind, source port, FCS error, overrun.
// R10 - Bits 6:0 count frames lost to overrun; a read clears them.
// R11 - Bit 7 flags counter wrap; a read clears it.
// R12 - Flow control bit 5 enables pause frames on buffer water marks.
// R13 - Target select bit 3: 0 picks EEPROM, 1 picks PHY.
// R14 - Bit 2 starts a read, bit 1 a write; EEPROM writes need bit 4.
// R15 - Host clears command bits after completion; device never does.
// R16 - Bit 5 requests configuration reload from EEPROM; host clears it afterwards.
// R17 - Busy bit 0 reads 1 while a management access runs.
// R18 - Bit 6 shows attached EEPROM size: 0 smaller, 1 larger.
// R19 - Clear-mode 0: done flags clear after being read; 1: write 1 only. Link change flag clears by write 1 only.
// R20 - Address register: PHY address low bits 7:6, word address 5:0.
// R21 - Two data registers hold low and high byte of the management word.
// R22 - Host loads address and data, selects, commands, then polls busy.
// R23 - Reserved bits read as 0 and ignore writes; receive control bits 6, 5 and 2 are stored and read back as written.
module shcsr_regs
	import shcsr_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// Avalon-MM slave
	input  wire logic [7:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [7:0]       avs_writedata,
	output logic      [7:0]       avs_readdata,
	output logic                  avs_waitrequest,
	// Link and transmit events (same clock)
	input  wire logic [1:0]       link_up,
	input  wire logic             slot1_done,
	input  wire logic             slot2_done,
	input  wire logic             tx_complete,
	// Transmit controls
	output logic                  transmit_request,
	output logic                  slot1_no_fcs,
	output logic                  slot2_no_fcs,
	// Receive side
	output shcsr_rx_ctl_t         rx_ctl,
	input  wire shcsr_rx_status_t rx_status,
	input  wire logic             lost_frame,
	// Management engine
	output shcsr_mgmt_req_t       mgmt_req,
	output logic                  eeprom_reload,
	input  wire logic             mgmt_active,
	input  wire logic             mgmt_rd_valid,
	input  wire logic [15:0]      mgmt_rd_data,
	input  wire logic             eeprom_size_flag
);

	// ===========================================
	// Bus decode
	logic       ack_reg;
	logic       [7:0] rdata_reg;
	wire        req      = (avs_read | avs_write) & ~ack_reg;
	wire        wr_stb   = avs_write & ~ack_reg;
	wire        rd_stb   = avs_read & ~ack_reg;
	wire        sel_ncr  = avs_address == NET_CONTROL_OFS;
	wire        sel_nsr  = avs_address == NET_STATUS_OFS;
	wire        sel_tcr  = avs_address == TX_CONTROL_OFS;
	wire        sel_rcr  = avs_address == RX_CONTROL_OFS;
	wire        sel_rsr  = avs_address == RX_STATUS_OFS;
	wire        sel_lost = avs_address == LOST_COUNT_OFS;
	wire        sel_fcr  = avs_address == FLOW_CONTROL_OFS;
	wire        sel_epc  = avs_address == MGMT_CONTROL_OFS;
	wire        sel_epa  = avs_address == MGMT_ADDRESS_OFS;
	wire        sel_dlo  = avs_address == MGMT_DATA_LO_OFS;
	wire        sel_dhi  = avs_address == MGMT_DATA_HI_OFS;

	assign avs_waitrequest = ~ack_reg;
	assign avs_readdata    = rdata_reg;

	// ===========================================
	// Register storage
	logic [7:0] ncr_reg;
	logic [7:0] tcr_reg;
	logic [7:0] rcr_reg;
	logic [7:0] fcr_reg;
	logic [7:0] epc_reg;
	logic [7:0] epa_reg;
	logic [7:0] dlo_reg;
	logic [7:0] dhi_reg;
	logic       link_change_flag_reg;
	logic       slot1_sent_flag_reg;
	logic       slot2_sent_flag_reg;
	logic [6:0] lost_packet_count_reg;
	logic       lost_count_wrap_reg;
	logic [1:0] link_prev_reg;
	logic       active_prev_reg;

	wire        flag_clear_mode = ncr_reg[CLEAR_MODE_BIT];
	wire        link_event      = link_up != link_prev_reg; // [R1]

	// ===========================================
	// Flag updates, set wins over clear
	wire        nsr_wr     = wr_stb & sel_nsr;
	wire        nsr_rd     = rd_stb & sel_nsr & ~flag_clear_mode; // [R3] [R19]
	wire        clr_link   = nsr_wr & avs_writedata[LINK_CHANGE_BIT]; // [R1]
	wire        clr_slot1  = (nsr_wr & avs_writedata[SLOT1_SENT_BIT]) | nsr_rd; // [R3]
	wire        clr_slot2  = (nsr_wr & avs_writedata[SLOT2_SENT_BIT]) | nsr_rd; // [R3]
	wire        link_next  = link_event | (link_change_flag_reg & ~clr_link); // [R1]
	wire        slot1_next = slot1_done | (slot1_sent_flag_reg & ~clr_slot1); // [R2]
	wire        slot2_next = slot2_done | (slot2_sent_flag_reg & ~clr_slot2); // [R2]

	// ===========================================
	// Lost frame counter, event wins over read clear
	wire        lost_rd    = rd_stb & sel_lost;
	wire [6:0]  count_base = lost_rd ? 7'h00 : lost_packet_count_reg; // [R10]
	wire        count_wrap = lost_frame & (count_base == COUNT_MAX); // [R11]
	wire [6:0]  count_next = lost_frame ? count_base + 7'h01 : count_base; // [R10]
	wire        wrap_next  = count_wrap | (lost_count_wrap_reg & ~lost_rd); // [R11]

	// ===========================================
	// Transmit request: host sets, completion clears
	wire        tcr_wr     = wr_stb & sel_tcr;
	wire [7:0]  tcr_wval   = avs_writedata & TX_CONTROL_MASK; // [R5] [R23]
	wire        transmit_request_next = tx_complete ? 1'b0 : (tcr_wr ? tcr_wval[TX_REQUEST_BIT] : tcr_reg[TX_REQUEST_BIT]); // [R4]
	wire [7:0]  tcr_next   = {(tcr_wr ? tcr_wval[7:1] : tcr_reg[7:1]), transmit_request_next};

	// ===========================================
	// Management data: host writes, engine read result loads
	wire        mgmt_start = mgmt_active & ~active_prev_reg;
	wire [7:0]  dlo_next   = mgmt_rd_valid ? mgmt_rd_data[7:0] : ((wr_stb & sel_dlo) ? avs_writedata : dlo_reg); // [R21]
	wire [7:0]  dhi_next   = mgmt_rd_valid ? mgmt_rd_data[15:8] : ((wr_stb & sel_dhi) ? avs_writedata : dhi_reg); // [R21]

	// ===========================================
	// Read mux
	wire [7:0]  nsr_val  = {2'b00, link_change_flag_reg, 1'b0, slot2_sent_flag_reg, slot1_sent_flag_reg, 2'b00};
	wire [7:0]  rsr_val  = {1'b0, rx_status}; // [R9]
	wire [7:0]  lost_val = {lost_count_wrap_reg, lost_packet_count_reg};
	wire [7:0]  epc_val  = {1'b0, eeprom_size_flag, epc_reg[5:1], mgmt_active}; // [R17] [R18]
	wire [7:0]  rd_mux   = sel_ncr  ? ncr_reg :
	                       sel_nsr  ? nsr_val :
	                       sel_tcr  ? tcr_reg :
	                       sel_rcr  ? rcr_reg :
	                       sel_rsr  ? rsr_val :
	                       sel_lost ? lost_val :
	                       sel_fcr  ? fcr_reg :
	                       sel_epc  ? epc_val :
	                       sel_epa  ? epa_reg :
	                       sel_dlo  ? dlo_reg :
	                       sel_dhi  ? dhi_reg : 8'h00; // [R23]

	// ===========================================
	// Outputs to the datapath
	assign transmit_request           = tcr_reg[TX_REQUEST_BIT]; // [R4]
	assign slot1_no_fcs               = tcr_reg[SLOT1_NO_FCS_BIT]; // [R5]
	assign slot2_no_fcs               = tcr_reg[SLOT2_NO_FCS_BIT]; // [R5]
	assign rx_ctl.receive_enable      = rcr_reg[RX_ENABLE_BIT]; // [R6]
	assign rx_ctl.promiscuous_enable  = rcr_reg[PROMISC_BIT]; // [R6]
	assign rx_ctl.pass_all_multicast  = rcr_reg[PASS_MCAST_BIT]; // [R6]
	assign rx_ctl.drop_bad_fcs        = rcr_reg[DROP_BAD_FCS_BIT]; // [R7]
	assign rx_ctl.hash_every_address  = rcr_reg[HASH_ALL_BIT]; // [R8]
	assign rx_ctl.flow_enable         = fcr_reg[FLOW_ENABLE_BIT]; // [R12]
	assign mgmt_req.mgmt_target_select = epc_reg[TARGET_SEL_BIT]; // [R13]
	assign mgmt_req.is_write          = epc_reg[WRITE_CMD_BIT];
	// Start on a command while idle; EEPROM write needs its enable
	assign mgmt_req.go = ~mgmt_active & ~mgmt_start_seen(epc_reg) & (epc_reg[READ_CMD_BIT] |
	                     (epc_reg[WRITE_CMD_BIT] & (epc_reg[TARGET_SEL_BIT] | epc_reg[WRITE_EN_BIT]))); // [R14]
	assign mgmt_req.phy_address_low   = epa_reg[7:6]; // [R20]
	assign mgmt_req.mgmt_word_address = epa_reg[5:0]; // [R20]
	assign mgmt_req.data              = {dhi_reg, dlo_reg}; // [R21]
	assign eeprom_reload              = epc_reg[RELOAD_BIT]; // [R16]

	// Command held after completion must not restart: blocked until host clears
	logic       done_hold_reg;
	function automatic logic mgmt_start_seen(input logic [7:0] c);
		mgmt_start_seen = done_hold_reg & (c[READ_CMD_BIT] | c[WRITE_CMD_BIT]);
	endfunction : mgmt_start_seen

	wire        cmd_bits  = epc_reg[READ_CMD_BIT] | epc_reg[WRITE_CMD_BIT];
	wire        hold_next = (mgmt_start | done_hold_reg) & cmd_bits; // [R15]

	// ===========================================
	// Sequential logic
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_reg               <= 1'b0;
			rdata_reg             <= BYTE_RST;
			ncr_reg               <= BYTE_RST;
			tcr_reg               <= BYTE_RST;
			rcr_reg               <= BYTE_RST; // [R6]
			fcr_reg               <= BYTE_RST;
			epc_reg               <= BYTE_RST;
			epa_reg               <= MGMT_ADDRESS_RST;
			dlo_reg               <= BYTE_RST;
			dhi_reg               <= BYTE_RST;
			link_change_flag_reg  <= 1'b0;
			slot1_sent_flag_reg   <= 1'b0;
			slot2_sent_flag_reg   <= 1'b0;
			lost_packet_count_reg <= 7'h00;
			lost_count_wrap_reg   <= 1'b0;
			link_prev_reg         <= link_up; // [R1]
			active_prev_reg       <= 1'b0;
			done_hold_reg         <= 1'b0;
		end else begin
			ack_reg               <= req;
			rdata_reg             <= rd_stb ? rd_mux : rdata_reg;
			link_prev_reg         <= link_up;
			active_prev_reg       <= mgmt_active;
			done_hold_reg         <= hold_next;
			link_change_flag_reg  <= link_next;
			slot1_sent_flag_reg   <= slot1_next;
			slot2_sent_flag_reg   <= slot2_next;
			lost_packet_count_reg <= count_next;
			lost_count_wrap_reg   <= wrap_next;
			tcr_reg               <= tcr_next;
			dlo_reg               <= dlo_next;
			dhi_reg               <= dhi_next;
			if (wr_stb & sel_ncr) begin
				ncr_reg <= avs_writedata & NET_CONTROL_MASK; // [R23]
			end
			if (wr_stb & sel_rcr) begin
				rcr_reg <= avs_writedata & RX_CONTROL_MASK;
			end
			if (wr_stb & sel_fcr) begin
				fcr_reg <= avs_writedata & FLOW_CONTROL_MASK;
			end
			if (wr_stb & sel_epc) begin
				epc_reg <= avs_writedata & MGMT_CONTROL_MASK; // [R15] [R16]
			end
			if (wr_stb & sel_epa) begin
				epa_reg <= avs_writedata; // [R20]
			end
		end
	end

endmodule : shcsr_regs

/* File: verification/shcsr_properties.sv */
// Checker: concurrent properties of the switch host register bank
`timescale 1ns/100ps
module shcsr_properties
	import shcsr_pkg::*;
(
	// Clock, reset and bus
	input wire logic             clk,
	input wire logic             sys_rst,
	input wire logic [7:0]       avs_address,
	input wire logic             avs_read,
	input wire logic             avs_write,
	input wire logic [7:0]       avs_writedata,
	input wire logic [7:0]       avs_readdata,
	input wire logic             avs_waitrequest,
	// Block side
	input wire logic             tx_complete,
	input wire logic             transmit_request,
	input wire logic             slot1_no_fcs,
	input wire logic             slot2_no_fcs,
	input wire shcsr_rx_ctl_t    rx_ctl,
	input wire shcsr_rx_status_t rx_status,
	input wire shcsr_mgmt_req_t  mgmt_req,
	input wire logic             eeprom_reload,
	input wire logic             mgmt_active,
	input wire logic             eeprom_size_flag
);
	// ===========================================
	// Taken requests
	wire logic take  = (avs_read | avs_write) & avs_waitrequest;
	wire logic wr_tx = take & avs_write & (avs_address == TX_CONTROL_OFS);
	wire logic wr_rx = take & avs_write & (avs_address == RX_CONTROL_OFS);
	wire logic wr_fc = take & avs_write & (avs_address == FLOW_CONTROL_OFS);
	wire logic wr_ep = take & avs_write & (avs_address == MGMT_CONTROL_OFS);
	wire logic rd_rs = take & avs_read & (avs_address == RX_STATUS_OFS);
	wire logic rd_ep = take & avs_read & (avs_address == MGMT_CONTROL_OFS);
	wire logic rd_un = take & avs_read & (avs_address == 8'h03);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ===========================================
	// Properties
	a_ack_single: assert property (take |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest answer not one cycle");
	a_fcs_load: assert property (wr_tx |=> slot2_no_fcs == avs_writedata[3] && slot1_no_fcs == avs_writedata[1])
		else $error("fcs controls wrong");
	a_transmit_request_done: assert property (tx_complete && !wr_tx |=> !transmit_request)
		else $error("transmit request not cleared");
	a_transmit_request_load: assert property (wr_tx && !tx_complete |=> transmit_request == avs_writedata[0])
		else $error("transmit request not loaded");
	a_rx_ctl_load: assert property (wr_rx |=> rx_ctl[5:1] == {avs_writedata[0], avs_writedata[1],
		avs_writedata[3], avs_writedata[4], avs_writedata[7]}) else $error("receive controls wrong");
	a_flow_load: assert property (wr_fc |=> rx_ctl.flow_enable == avs_writedata[5])
		else $error("flow enable wrong");
	a_mgmt_load: assert property (wr_ep |=> eeprom_reload == avs_writedata[5] &&
		mgmt_req.mgmt_target_select == avs_writedata[3]) else $error("management controls wrong");
	a_status_read: assert property (rd_rs |=> avs_readdata == {1'b0, $past(rx_status)})
		else $error("receive status read wrong");
	a_busy_read: assert property (rd_ep |=> avs_readdata[0] == $past(mgmt_active) &&
		avs_readdata[6] == $past(eeprom_size_flag)) else $error("busy or size bit wrong");
	a_reserved_zero: assert property (rd_un |=> avs_readdata == 8'h00)
		else $error("unmapped read not zero");
	c_tx_write: cover property (wr_tx);
	c_busy_seen: cover property (rd_ep && mgmt_active);
	c_tx_done: cover property (tx_complete && transmit_request);
endmodule : shcsr_properties
bind shcsr_regs shcsr_properties u_props (.*);

/* File: verification/shcsr_mgmt_model.sv */
// Partner model: management engine answering the register bank
`timescale 1ns/100ps
module shcsr_mgmt_model
	import shcsr_pkg::*;
#(
	parameter int DELAY = 4
)
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            sys_rst,
	// Command and answer
	input  wire shcsr_mgmt_req_t mgmt_req,
	output logic                 mgmt_active,
	output logic                 mgmt_rd_valid,
	output logic [15:0]          mgmt_rd_data
);
	logic [15:0] mem [128];
	logic [7:0]  cnt_reg;
	wire  [6:0]  key = {mgmt_req.mgmt_target_select, mgmt_req.mgmt_word_address};
	// ===========================================
	// Busy window, then store or answer
	always_ff @(posedge clk) begin
		mgmt_rd_valid <= 1'b0;
		mgmt_rd_data  <= ~mgmt_rd_data;
		if (sys_rst) begin
			mgmt_active  <= 1'b0;
			cnt_reg      <= 8'h00;
			mgmt_rd_data <= 16'hA5A5;
		end else if (!mgmt_active && mgmt_req.go) begin
			mgmt_active <= 1'b1;
			cnt_reg     <= 8'(DELAY);
		end else if (mgmt_active && cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end else if (mgmt_active) begin
			mgmt_active <= 1'b0;
			if (mgmt_req.is_write) begin
				mem[key] <= mgmt_req.data;
			end else begin
				mgmt_rd_valid <= 1'b1;
				mgmt_rd_data  <= mem[key];
			end
		end
	end
endmodule : shcsr_mgmt_model

/* File: verification/switch_host_control_status_regs_tb.sv */
// Testbench: self-checking bench of the switch host register bank
`timescale 1ns/100ps
module switch_host_control_status_regs_tb
	import shcsr_pkg::*;
;
	logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, slot1_done, slot2_done, tx_complete, lost_frame;
	logic eeprom_size_flag, transmit_request, slot1_no_fcs, slot2_no_fcs, eeprom_reload, mgmt_active, mgmt_rd_valid;
	logic [7:0] avs_address, avs_writedata, avs_readdata, last, d;
	logic [1:0] link_up;
	logic [3:0] ev;
	logic [15:0] mgmt_rd_data;
	logic [23:0] note;
	logic [23:0] notes [$];
	shcsr_rx_ctl_t rx_ctl;
	shcsr_rx_status_t rx_status;
	shcsr_mgmt_req_t mgmt_req;
	int mismatches, total_checks, cycles;
	integer seed;
	logic [7:0] rst_addr [11] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
	logic [7:0] rst_val [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h40, 8'h00, 8'h00};
	assign {lost_frame, tx_complete, slot2_done, slot1_done} = ev;
	shcsr_regs u_dut (.*);
	shcsr_mgmt_model #(.DELAY(4)) u_model (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ===========================================
	// Tasks
	task automatic chk(input string n, input logic [7:0] e, g, m);
		total_checks++;
		if (((g ^ e) & m) !== 8'h00) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [7:0] a, v);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e, m);
		notes.push_back({a, m, e});
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		last = avs_readdata;
		avs_read <= 1'b0;
	endtask : rd
	task automatic pulse(input logic [3:0] w, input int n);
		@(posedge clk);
		ev <= w;
		repeat (n) @(posedge clk);
		ev <= 4'h0;
	endtask : pulse
	task automatic mgmt(input logic [7:0] c);
		int i;
		wr(MGMT_CONTROL_OFS, c);
		i = 0;
		do begin
			rd(MGMT_CONTROL_OFS, 8'h00, 8'h00);
			i++;
		end while (last[0] !== 1'b0 && i < 50);
		rd(MGMT_CONTROL_OFS, c | 8'h40, 8'hFF);
		wr(MGMT_CONTROL_OFS, c & 8'h38);
	endtask : mgmt
	// ===========================================
	// Read monitor and timeout
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0 && notes.size() > 0) begin
			note = notes.pop_front();
			if (note[15:8] != 8'h00) chk($sformatf("register %h", note[23:16]), note[7:0], avs_readdata, note[15:8]);
		end
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	// ===========================================
	// Main sequence
	initial begin
		seed = 32'h3ffd;
		{sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 18'h0};
		{link_up, ev, rx_status, eeprom_size_flag, cycles} = {13'h0, 1'b1, 32'h0};
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (rst_addr[i]) rd(rst_addr[i], rst_val[i], 8'hFF);
		wr(TX_CONTROL_OFS, 8'hFF);
		rd(TX_CONTROL_OFS, 8'h0B, 8'hFF);
		chk("tx controls", 8'h07, {5'h0, slot2_no_fcs, slot1_no_fcs, transmit_request}, 8'hFF);
		pulse(4'h4, 1);
		rd(TX_CONTROL_OFS, 8'h0A, 8'hFF);
		wr(FLOW_CONTROL_OFS, 8'hFF);
		rd(FLOW_CONTROL_OFS, 8'h20, 8'hFF);
		wr(8'h03, 8'hFF);
		rd(8'h03, 8'h00, 8'hFF);
		repeat (4) begin
			d = 8'($random(seed));
			wr(RX_CONTROL_OFS, d);
			rd(RX_CONTROL_OFS, d, 8'hFF);
			chk("rx_ctl", {2'b0, d[0], d[1], d[3], d[4], d[7], 1'b1}, {2'b0, rx_ctl}, 8'hFF);
			rx_status <= shcsr_rx_status_t'(d[6:0] ^ 7'h55);
			rd(RX_STATUS_OFS, {1'b0, d[6:0] ^ 7'h55}, 8'hFF);
		end
		link_up <= 2'b01;
		rd(NET_STATUS_OFS, 8'h20, 8'hFF);
		rd(NET_STATUS_OFS, 8'h20, 8'hFF);
		wr(NET_STATUS_OFS, 8'h20);
		rd(NET_STATUS_OFS, 8'h00, 8'hFF);
		pulse(4'h3, 1);
		rd(NET_STATUS_OFS, 8'h0C, 8'hFF);
		rd(NET_STATUS_OFS, 8'h00, 8'hFF);
		wr(NET_CONTROL_OFS, 8'hFF);
		rd(NET_CONTROL_OFS, 8'h20, 8'hFF);
		pulse(4'h3, 1);
		rd(NET_STATUS_OFS, 8'h0C, 8'hFF);
		wr(NET_STATUS_OFS, 8'h04);
		rd(NET_STATUS_OFS, 8'h08, 8'hFF);
		pulse(4'h8, 3);
		rd(LOST_COUNT_OFS, 8'h03, 8'hFF);
		rd(LOST_COUNT_OFS, 8'h00, 8'hFF);
		pulse(4'h8, 128);
		rd(LOST_COUNT_OFS, 8'h80, 8'hFF);
		wr(MGMT_ADDRESS_OFS, 8'hC5);
		rd(MGMT_ADDRESS_OFS, 8'hC5, 8'hFF);
		wr(MGMT_DATA_LO_OFS, 8'h34);
		wr(MGMT_DATA_HI_OFS, 8'h12);
		wr(MGMT_CONTROL_OFS, 8'h02);
		rd(MGMT_CONTROL_OFS, 8'h42, 8'hFF);
		mgmt(8'h0A);
		wr(MGMT_DATA_LO_OFS, 8'h78);
		wr(MGMT_DATA_HI_OFS, 8'h56);
		mgmt(8'h12);
		mgmt(8'h0C);
		rd(MGMT_DATA_LO_OFS, 8'h34, 8'hFF);
		rd(MGMT_DATA_HI_OFS, 8'h12, 8'hFF);
		mgmt(8'h04);
		rd(MGMT_DATA_LO_OFS, 8'h78, 8'hFF);
		rd(MGMT_DATA_HI_OFS, 8'h56, 8'hFF);
		wr(MGMT_CONTROL_OFS, 8'h20);
		chk("reload", 8'h01, {7'h0, eeprom_reload}, 8'hFF);
		wr(MGMT_CONTROL_OFS, 8'h00);
		chk("reload off", 8'h00, {7'h0, eeprom_reload}, 8'hFF);
		wr(RX_CONTROL_OFS, 8'hFF);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(RX_CONTROL_OFS, 8'h00, 8'hFF);
		stop_test();
	end
endmodule : switch_host_control_status_regs_tb
